// *** hdl/tm2_timer.sv ***
// Timer 2 core: 16-bit auto-reload timer/counter with up/down option
`timescale 1ns/1ns
`default_nettype none
`include "tm2_consts.svh"
module tm2_timer (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // External pins
  input wire logic i_external_count_pin,
  input wire logic i_direction_pin,
  // Control bits
  input wire logic i_run_control,
  input wire logic i_timer_counter_select,
  input wire logic i_capture_reload_select,
  input wire logic i_rx_clock_source_sel,
  input wire logic i_tx_clock_source_sel,
  input wire logic i_external_pin_enable,
  input wire logic i_down_count_enable,
  // Reload value
  input wire tm2_pkg::tm2_byte_t i_reload_high_byte,
  input wire tm2_pkg::tm2_byte_t i_reload_low_byte,
  // Software writes to count
  input wire logic i_count_write,
  input wire tm2_pkg::tm2_count_t i_count_wdata,
  // Software clears of flags
  input wire logic i_overflow_flag_clr,
  input wire logic i_external_flag_clr,
  // Status
  output tm2_pkg::tm2_byte_t o_count_high_byte,
  output tm2_pkg::tm2_byte_t o_count_low_byte,
  output logic o_overflow_flag,
  output logic o_external_flag,
  output tm2_pkg::tm2_mode_e o_mode,
  output logic o_irq
);
  import tm2_pkg::*;

  logic tick_div;
  logic cnt_fall;
  logic dir_level;
  logic dir_fall;

  // Internal clock divided by twelve
  tm2_prescaler u_pre (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .o_tick(tick_div)
  );

  // Count pin synchroniser
  tm2_pin_sync u_cnt_sync (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_pin(i_external_count_pin),
    .o_level(),
    .o_fall(cnt_fall)
  );

  // Direction pin synchroniser
  tm2_pin_sync u_dir_sync (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_pin(i_direction_pin),
    .o_level(dir_level),
    .o_fall(dir_fall)
  );

  tm2_byte_t count_high_byte;
  tm2_byte_t count_low_byte;
  tm2_byte_t next_count_high_byte;
  tm2_byte_t next_count_low_byte;
  logic overflow_flag;
  logic external_flag;
  logic next_overflow_flag;
  logic next_external_flag;
  tm2_mode_e mode;
  logic serial_clk;
  logic updown;
  logic count_en;
  logic count_up;
  logic low_carry;
  tm2_count_t count;
  tm2_count_t reload;
  logic ovf_evt;
  logic unf_evt;
  logic ext_reload_evt;

  // Mode decode from serial clock and capture select bits
  always_comb begin
    serial_clk = i_rx_clock_source_sel | i_tx_clock_source_sel;
    if (serial_clk) begin
      mode = TM2_MODE_BAUD;
    end else if (i_capture_reload_select) begin
      mode = TM2_MODE_CAPTURE;
    end else begin
      mode = TM2_MODE_RELOAD;
    end
  end

  // Count input selection, direction and wrap detection
  always_comb begin
    count = {count_high_byte, count_low_byte};
    reload = {i_reload_high_byte, i_reload_low_byte};
    updown = (mode == TM2_MODE_RELOAD) && i_down_count_enable;
    // Divided clock or falling edge of the count pin, gated by run
    count_en = i_run_control && (i_timer_counter_select ? cnt_fall : tick_div);
    // Direction pin level sets the count direction only in up/down mode
    count_up = updown ? dir_level : 1'b1;
    low_carry = (count_low_byte == 8'hFF);
    ovf_evt = count_en && count_up && (count == `TM2_ALL_ONES);
    unf_evt = count_en && !count_up && (count == reload);
    // Standard reload: direction pin fall reloads when enabled
    ext_reload_evt = (mode == TM2_MODE_RELOAD) && !updown && i_external_pin_enable && dir_fall;
  end

  // Next count and flags
  always_comb begin
    next_count_high_byte = count_high_byte;
    next_count_low_byte = count_low_byte;
    next_overflow_flag = overflow_flag;
    next_external_flag = external_flag;
    if (i_count_write) begin
      next_count_high_byte = i_count_wdata[15:8];
      next_count_low_byte = i_count_wdata[7:0];
    end else if (ovf_evt || ext_reload_evt) begin
      // Reload pair into count; baud mode also reloads
      next_count_high_byte = i_reload_high_byte;
      next_count_low_byte = i_reload_low_byte;
    end else if (unf_evt) begin
      next_count_high_byte = 8'hFF;
      next_count_low_byte = 8'hFF;
    end else if (count_en && count_up) begin
      // Low byte increments and carries into high byte
      next_count_low_byte = count_low_byte + 8'h01;
      if (low_carry) begin
        next_count_high_byte = count_high_byte + 8'h01;
      end
    end else if (count_en) begin
      // Down count: low byte borrows from high byte
      next_count_low_byte = count_low_byte - 8'h01;
      if (count_low_byte == 8'h00) begin
        next_count_high_byte = count_high_byte - 8'h01;
      end
    end
    // Software clear; a coinciding set wins
    if (i_overflow_flag_clr) begin
      next_overflow_flag = 1'b0;
    end
    if ((ovf_evt || unf_evt) && !serial_clk) begin
      next_overflow_flag = 1'b1;
    end
    if (i_external_flag_clr) begin
      next_external_flag = 1'b0;
    end
    if (updown && (ovf_evt || unf_evt)) begin
      next_external_flag = ~external_flag;
    end else if (ext_reload_evt) begin
      next_external_flag = 1'b1;
    end
  end

  // Count and flag registers
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count_high_byte <= 8'h00;
      count_low_byte <= 8'h00;
      overflow_flag <= 1'b0;
      external_flag <= 1'b0;
    end else begin
      count_high_byte <= next_count_high_byte;
      count_low_byte <= next_count_low_byte;
      overflow_flag <= next_overflow_flag;
      external_flag <= next_external_flag;
    end
  end

  // Outputs; external flag excluded from interrupt whenever down count enable is set, in any mode
  assign o_count_high_byte = count_high_byte;
  assign o_count_low_byte = count_low_byte;
  assign o_overflow_flag = overflow_flag;
  assign o_external_flag = external_flag;
  assign o_mode = mode;
  assign o_irq = overflow_flag | (external_flag & ~i_down_count_enable);
endmodule
`default_nettype wire

// *** hdl/tm2_consts.svh ***
// Timing counts, widths and reset values for the timer 2 block
`ifndef TM2_CONSTS_SVH
`define TM2_CONSTS_SVH

`define TM2_CLK_HZ 50000000
`define TM2_PRESCALE 12
`define TM2_PRESCALE_W 4
`define TM2_COUNT_W 16
`define TM2_BYTE_W 8
`define TM2_ALL_ONES 16'hFFFF
`define TM2_COUNT_RST 16'h0000
`define TM2_SYNC_STAGES 3

`endif

// *** hdl/tm2_pkg.sv ***
// Types shared by the timer 2 block
package tm2_pkg;
  typedef logic [15:0] tm2_count_t;
  typedef logic [7:0] tm2_byte_t;
  typedef enum logic [1:0] {
    TM2_MODE_CAPTURE,
    TM2_MODE_RELOAD,
    TM2_MODE_BAUD
  } tm2_mode_e;
endpackage

// *** hdl/tm2_pin_sync.sv ***
// Three-stage synchroniser with agreement filter and falling-edge pulse
`timescale 1ns/1ns
`default_nettype none
`include "tm2_consts.svh"
module tm2_pin_sync (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Pin
  input wire logic i_pin,
  // Filtered level and edge
  output logic o_level,
  output logic o_fall
);
  logic [2:0] sync;
  logic level;
  logic next_level;
  logic fall;
  logic next_fall;

  // Level changes only once stage two and three agree
  always_comb begin
    next_level = level;
    if (sync[1] == sync[2]) begin
      next_level = sync[2];
    end
    next_fall = level & ~next_level;
  end

  // Synchroniser chain and filtered state
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync <= 3'h7;
      level <= 1'b1;
      fall <= 1'b0;
    end else begin
      sync <= {sync[1:0], i_pin};
      level <= next_level;
      fall <= next_fall;
    end
  end

  assign o_level = level;
  assign o_fall = fall;
endmodule
`default_nettype wire

// *** hdl/tm2_prescaler.sv ***
// Divide-by-twelve enable pulse generator
`timescale 1ns/1ns
`default_nettype none
`include "tm2_consts.svh"
module tm2_prescaler (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Tick out
  output logic o_tick
);
  localparam logic [`TM2_PRESCALE_W-1:0] LAST = `TM2_PRESCALE_W'(`TM2_PRESCALE - 1);
  logic [`TM2_PRESCALE_W-1:0] cnt;
  logic [`TM2_PRESCALE_W-1:0] next_cnt;

  // Wrap after twelve cycles
  always_comb begin
    next_cnt = (cnt == LAST) ? '0 : cnt + `TM2_PRESCALE_W'(1);
  end

  // Counter register
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign o_tick = (cnt == LAST);
endmodule
`default_nettype wire

// *** verif/tm2_pins.sv ***
// Model of the external count and direction pins
`timescale 1ns/1ns
`default_nettype none
module tm2_pins (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic i_dir,
  output logic o_count_pin,
  output logic o_direction_pin
);
  logic [2:0] ph = 3'h0;
  // One falling edge every eight clocks while enabled, idle high
  always @(posedge i_clk) begin
    ph <= i_go ? ph + 3'h1 : 3'h0;
    o_direction_pin <= i_dir;
  end
  assign o_count_pin = ~ph[2];
endmodule
`default_nettype wire

// *** verif/tm2_timer_asserts.sv ***
// Assertions on the timer 2 ports
`timescale 1ns/1ns
`default_nettype none
module tm2_timer_asserts (
  input wire logic i_clk, i_reset_n, i_run_control, i_count_write,
  input wire logic i_external_pin_enable, i_down_count_enable, i_capture_reload_select,
  input wire logic i_rx_clock_source_sel, i_tx_clock_source_sel,
  input wire logic i_overflow_flag_clr, i_external_flag_clr,
  input wire tm2_pkg::tm2_byte_t i_reload_high_byte, i_reload_low_byte,
  input wire tm2_pkg::tm2_byte_t o_count_high_byte, o_count_low_byte,
  input wire logic o_overflow_flag, o_external_flag, o_irq,
  input wire tm2_pkg::tm2_mode_e o_mode
);
  import tm2_pkg::*;
  // Joined count, reload and qualifiers
  wire logic [15:0] cnt = {o_count_high_byte, o_count_low_byte};
  wire logic [15:0] rld = {i_reload_high_byte, i_reload_low_byte};
  wire logic ser = i_rx_clock_source_sel | i_tx_clock_source_sel;
  wire logic dn = i_down_count_enable & !i_count_write;
  wire logic up_rl = (cnt == 16'hFFFF) & !dn & !i_count_write & (o_mode != TM2_MODE_CAPTURE);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  sequence ovf_rise;
    $rose(o_overflow_flag);
  endsequence
  // Count, flag and mode relations
  chk_run_hold: assert property (!i_run_control && !i_count_write && !i_external_pin_enable |=> $stable(cnt))
    else $error("count moved while stopped");
  chk_step_one: assert property ($changed(cnt) && !$past(i_count_write) && cnt != 16'hFFFF && cnt != $past(rld)
    |-> cnt == $past(cnt) + 16'h1 || cnt == $past(cnt) - 16'h1) else $error("count jumped");
  chk_mode_map: assert property (o_mode == (ser ? TM2_MODE_BAUD : i_capture_reload_select ? TM2_MODE_CAPTURE
    : TM2_MODE_RELOAD)) else $error("bad mode");
  chk_irq_map: assert property (o_irq == (o_overflow_flag | (o_external_flag & !i_down_count_enable)))
    else $error("bad irq");
  chk_ovf_sticky: assert property (o_overflow_flag && !i_overflow_flag_clr |=> o_overflow_flag)
    else $error("flag dropped");
  chk_baud_noflag: assert property (ovf_rise |-> !$past(ser)) else $error("flag in baud");
  chk_up_reload: assert property (ovf_rise ##0 $past(up_rl) |-> cnt == $past(rld)) else $error("no reload");
  chk_down_ffff: assert property (ovf_rise ##0 ($past(dn) && $past(cnt) != 16'hFFFF) |-> cnt == 16'hFFFF)
    else $error("no FFFF load");
  chk_ext_toggle: assert property ($past(dn) && !$past(i_external_flag_clr) && $changed(o_external_flag)
    |-> cnt == 16'hFFFF || cnt == $past(rld)) else $error("stray toggle");
endmodule
bind tm2_timer tm2_timer_asserts chk (.*);
`default_nettype wire

// *** verif/tm2_timer_test.sv ***
// Self-checking bench for the timer 2 block
`timescale 1ns/1ns
`default_nettype none
module tm2_timer_test;
  import tm2_pkg::*;
  logic i_clk = 0, i_reset_n = 0, i_run_control = 0, i_timer_counter_select = 0;
  logic i_capture_reload_select = 0, i_rx_clock_source_sel = 0, i_tx_clock_source_sel = 0;
  logic i_external_pin_enable = 0, i_down_count_enable = 0, i_count_write = 0;
  logic i_overflow_flag_clr = 0, i_external_flag_clr = 0, go = 0, dir = 0;
  logic i_external_count_pin, i_direction_pin, o_overflow_flag, o_external_flag, o_irq;
  tm2_byte_t i_reload_high_byte = 8'h00, i_reload_low_byte = 8'h00, o_count_high_byte, o_count_low_byte;
  tm2_count_t i_count_wdata = 16'h0000;
  tm2_mode_e o_mode;
  int errors = 0, n_checks = 0;
  wire tm2_count_t cnt = {o_count_high_byte, o_count_low_byte};
  logic [2:0] tab [4] = '{3'h0, 3'h1, 3'h2, 3'h5};
  tm2_mode_e em [4] = '{TM2_MODE_RELOAD, TM2_MODE_CAPTURE, TM2_MODE_BAUD, TM2_MODE_BAUD};
  tm2_pins pins (.i_clk(i_clk), .i_go(go), .i_dir(dir), .o_count_pin(i_external_count_pin),
    .o_direction_pin(i_direction_pin));
  tm2_timer dut (.*);
  // Clock
  initial forever #10 i_clk = ~i_clk;
  // Shared helpers
  task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s exp %h got %h", nm, e, s);
    end
  endtask
  task give_verdict;
    $display("errors %0d checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic idle(int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic wait_ovf;
    int k;
    k = 0;
    while (o_overflow_flag !== 1'b1 && k < 200) begin
      idle(1);
      k++;
    end
    if (k == 200) begin
      errors++;
      give_verdict;
    end
    i_run_control = 0;
  endtask
  task automatic wr(tm2_count_t v);
    idle(1);
    i_count_wdata = v;
    i_count_write = 1;
    idle(1);
    i_count_write = 0;
  endtask
  task automatic clr(logic ov, logic ex);
    idle(1);
    {i_overflow_flag_clr, i_external_flag_clr} = {ov, ex};
    idle(1);
    {i_overflow_flag_clr, i_external_flag_clr} = 2'h0;
  endtask
  // Up count past the top with the direction pin low, then stop
  task automatic t_up;
    {i_reload_high_byte, i_reload_low_byte} = 16'h1234;
    wr(16'hFFFE);
    i_run_control = 1;
    wait_ovf;
    chk("reload", cnt, 16'h1234);
    chk("irq", o_irq, 1);
    idle(30);
    chk("hold", cnt, 16'h1234);
    chk("sticky", o_overflow_flag, 1);
  endtask
  // Up/down mode: underflow at the reload value, then overflow upward
  task automatic t_down;
    clr(1, 0);
    i_down_count_enable = 1;
    {i_reload_high_byte, i_reload_low_byte} = 16'h0010;
    wr(16'h0012);
    i_run_control = 1;
    wait_ovf;
    chk("under", cnt, 16'hFFFF);
    chk("xflag", o_external_flag, 1);
    clr(1, 0);
    chk("noirq", o_irq, 0);
    dir = 1;
    idle(8);
    wr(16'hFFFF);
    i_run_control = 1;
    wait_ovf;
    chk("upload", cnt, 16'h0010);
    chk("xflag2", o_external_flag, 0);
  endtask
  // Counter mode: falls on the count pin advance the count, prescaler ignored
  task automatic t_pin;
    int k;
    clr(1, 1);
    i_down_count_enable = 0;
    i_timer_counter_select = 1;
    wr(16'h0000);
    {i_run_control, go} = 2'h3;
    k = 0;
    while (cnt !== 16'h0003 && k < 100) begin
      idle(1);
      k++;
    end
    go = 0;
    idle(30);
    chk("pin", cnt, 16'h0003);
    i_run_control = 0;
  endtask
  // Mode selection table, then a serial-clock overflow without a flag
  task automatic t_mode;
    for (int m = 0; m < 4; m++) begin
      {i_rx_clock_source_sel, i_tx_clock_source_sel, i_capture_reload_select} = tab[m];
      idle(1);
      chk("mode", 16'(o_mode), 16'(em[m]));
    end
    i_timer_counter_select = 0;
    wr(16'hFFFF);
    i_run_control = 1;
    idle(30);
    i_run_control = 0;
    chk("baudflag", o_overflow_flag, 0);
  endtask
  // Standard reload with pin enable: a fall on the direction pin reloads and sets the flag
  task automatic t_ext;
    {i_rx_clock_source_sel, i_tx_clock_source_sel, i_capture_reload_select} = 3'h0;
    i_down_count_enable = 0;
    wr(16'h0005);
    i_external_pin_enable = 1;
    idle(8);
    chk("extpre", o_external_flag, 0);
    dir = 0;
    idle(10);
    chk("extload", cnt, 16'h0010);
    chk("extflag", o_external_flag, 1);
    chk("extirq", o_irq, 1);
    i_external_pin_enable = 0;
  endtask
  // Reset, scenarios, verdict
  initial begin
    idle(12);
    i_reset_n = 1;
    t_up;
    t_down;
    t_pin;
    t_mode;
    t_ext;
    give_verdict;
  end
endmodule
`default_nettype wire
